// ### rtl/asf_cfg.svh
// Offsets, field positions and timing counts of the serial block
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

// ***************
// Register offsets
// ***************
`define ASF_ADDR_STATUS    8'h00
`define ASF_ADDR_DATA      8'h04
`define ASF_ADDR_CTRL1     8'h08
`define ASF_ADDR_CTRL2     8'h0C
`define ASF_ADDR_CTRL3     8'h10
`define ASF_ADDR_BAUD      8'h14
`define ASF_ADDR_ARBCTL    8'h18
`define ASF_ADDR_ARBCNT    8'h1C

// ***************
// Status bits
// ***************
`define ASF_ST_TXE         7
`define ASF_ST_TC          6
`define ASF_ST_RXF         5
`define ASF_ST_IDLE        4
`define ASF_ST_OR          3
`define ASF_ST_NF          2
`define ASF_ST_FE          1
`define ASF_ST_PE          0

// ***************
// Control bits
// ***************
`define ASF_C1_PAR_EN      1
`define ASF_C1_PAR_ODD     0
`define ASF_C2_TXEIE       7
`define ASF_C2_TX_COMPLETE_IRQ_EN        6
`define ASF_C2_RXFIE       5
`define ASF_C2_IDLE_LINE_IRQ_EN        4
`define ASF_C2_TXEN        3
`define ASF_C2_RXEN        2
`define ASF_C2_BRK         0
`define ASF_C3_OVERRUN_IRQ_EN        3
`define ASF_C3_NOISE_IRQ_EN        2
`define ASF_C3_FRAMING_IRQ_EN        1
`define ASF_C3_PARITY_IRQ_EN        0
`define ASF_BD_PRESC_LSB   4
`define ASF_BD_RATE_LSB    0
`define ASF_AC_AM1         7
`define ASF_AC_AM0         6
`define ASF_AC_LOST        5
`define ASF_AC_ACLK        4
`define ASF_AC_DONE        3

// ***************
// Timing counts
// ***************
`define ASF_RT_PER_BIT     5'h10
`define ASF_RT_SAMPLE_A    5'h08
`define ASF_RT_SAMPLE_B    5'h09
`define ASF_RT_SAMPLE_C    5'h0A
`define ASF_IDLE_RT        8'hA0
`define ASF_RT_PRE_DIV     10'h004
`define ASF_ARB_BUS_DIV    2'h3
`define ASF_FRAME_PAR      4'hB
`define ASF_FRAME_NOPAR    4'hA
`define ASF_DATA_PAR       4'h9
`define ASF_DATA_NOPAR     4'h8

`endif

// ### rtl/asf_pkg.sv
// Types shared by the serial block modules
package asf_pkg;

   typedef enum logic [1:0] {
      ASF_RX_IDLE  = 2'b00,
      ASF_RX_START = 2'b01,
      ASF_RX_DATA  = 2'b10,
      ASF_RX_STOP  = 2'b11
   } asf_rx_e;

   typedef enum logic [0:0] {
      ASF_TX_IDLE  = 1'b0,
      ASF_TX_SHIFT = 1'b1
   } asf_tx_e;

   typedef enum logic [1:0] {
      ASF_AM_IDLE    = 2'b00,
      ASF_AM_MEASURE = 2'b01,
      ASF_AM_ARBIT   = 2'b10,
      ASF_AM_RSVD    = 2'b11
   } asf_am_e;

endpackage

// ### rtl/asf_baud_if.sv
// Baud selection and tick signals between the top and the baud generator
`timescale 1ns/1ps
interface asf_baud_if;
   logic [1:0] prescaleSelect;
   logic [2:0] rateDivisorSelect;
   logic       baudSourceSelect;
   logic       prescaleTick;
   logic       oversampleTick;
   modport gen  (input prescaleSelect, input rateDivisorSelect, input baudSourceSelect,
                 output prescaleTick, output oversampleTick);
   modport user (output prescaleSelect, output rateDivisorSelect, output baudSourceSelect,
                 input prescaleTick, input oversampleTick);
endinterface

// ### rtl/asf_baud_gen.sv
// Baud prescaler and rate divisor producing prescaler and oversample ticks
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_baud_gen
   import asf_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   asf_baud_if.gen   bif
);
   typedef struct packed {
      logic [5:0] preAcc;
      logic [9:0] rtCnt;
      logic       presc;
      logic       rt;
   } asf_bg_s;

   asf_bg_s s_q, s_d;
   logic [5:0] bpd;
   logic [5:0] acc;
   logic [9:0] rtLast;

   // Quarter-step accumulator models the four-times source on one clock;
   // limitation: at most one prescaler tick per bus clock
   always_comb begin
      s_d = s_q;
      case (bif.prescaleSelect)
         2'h0: bpd = 6'h01;
         2'h1: bpd = 6'h03;
         2'h2: bpd = 6'h04;
         default: bpd = 6'h0D;
      endcase
      acc = s_q.preAcc + (bif.baudSourceSelect ? 6'h04 : 6'h01);
      rtLast = 10'((`ASF_RT_PRE_DIV << bif.rateDivisorSelect) - 10'h001);
      s_d.presc = 1'b0;
      s_d.rt = 1'b0;
      if (acc >= bpd) begin
         s_d.presc = 1'b1;
         s_d.preAcc = ((acc - bpd) >= bpd) ? (bpd - 6'h01) : (acc - bpd);
      end else begin
         s_d.preAcc = acc;
      end
      if (s_d.presc) begin
         if (s_q.rtCnt >= rtLast) begin
            s_d.rtCnt = 10'h000;
            s_d.rt = 1'b1;
         end else begin
            s_d.rtCnt = s_q.rtCnt + 10'h001;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bif.prescaleTick   = s_q.presc;
   assign bif.oversampleTick = s_q.rt;
endmodule

// ### rtl/asf_arbiter.sv
// Arbiter counter: bit-time measurement and bus arbitration
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_arbiter
   import asf_pkg::*;
#(
   parameter int CNT_W = 9
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             arbTick,
   input  wire logic [1:0]       mode,
   input  wire logic             ctlWrite,
   input  wire logic             lostClear,
   input  wire logic             lineLevel,
   input  wire logic             txLevel,
   output logic [CNT_W-1:0]      count,
   output logic                  overflow,
   output logic                  lost,
   output logic                  done
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             ovf;
      logic             lost;
      logic             done;
      logic             run;
      logic             lineQ;
   } asf_arb_s;

   asf_arb_s s_q, s_d;
   logic fall;
   logic rise;

   always_comb begin
      s_d = s_q;
      fall = s_q.lineQ & ~lineLevel;
      rise = ~s_q.lineQ & lineLevel;
      s_d.lineQ = lineLevel;
      if (ctlWrite) s_d.done = 1'b0;
      if (lostClear) s_d.lost = 1'b0;
      case (asf_am_e'(mode))
         ASF_AM_MEASURE: begin
            if (s_q.run) begin
               if (arbTick) {s_d.ovf, s_d.cnt} = {s_q.ovf, s_q.cnt} + 1'b1;
               if (arbTick && (&s_q.cnt)) s_d.ovf = 1'b1;
               if (rise) begin
                  s_d.run = 1'b0;
                  s_d.done = 1'b1;
               end
            end else if (fall && !s_q.done) begin
               s_d.run = 1'b1;
               s_d.cnt = '0;
               s_d.ovf = 1'b0;
            end
         end
         ASF_AM_ARBIT: begin
            s_d.run = 1'b0;
            if (fall || rise) begin
               s_d.cnt = '0;
            end else if (arbTick) begin
               {s_d.ovf, s_d.cnt} = {s_q.ovf, s_q.cnt} + 1'b1;
               if (&s_q.cnt) s_d.ovf = 1'b1;
            end
            if (arbTick && txLevel && !lineLevel) s_d.lost = 1'b1;
         end
         default: begin
            // Idle and the unused code hold the counter cleared
            s_d.cnt = '0;
            s_d.ovf = 1'b0;
            s_d.run = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.lineQ <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign count    = s_q.cnt;
   assign overflow = s_q.ovf;
   assign lost     = s_q.lost;
   assign done     = s_q.done;
endmodule

// ### rtl/asf_serial_top.sv
// Serial receiver, transmitter, flags, baud selection and arbiter behind APB
//
// Function
// - Stop bit sampled three times at oversample phases 8, 9 and 10.
// - Each bit is sixteen oversample ticks, counted from the start edge.
// - Transmit-empty set when data moves to shifter; interrupt if enabled.
// - Transmit-complete set when all empty, no break; interrupt if enabled.
// - Receive-full set when a character is loaded; interrupt if enabled.
// - Idle flag after ten ones on the receive line; interrupt if enabled.
// - Overrun keeps old character, drops new, sets flag; error interrupt.
// - Noise in any sampled bit sets noise flag; error interrupt if enabled.
// - Zero at stop bit sets framing error; error interrupt if enabled.
// - Bad parity sets parity error flag; error interrupt if enabled.
// - Block keeps running in wait; any enabled request gives a wake request.
// - Baud clock is bus clock over prescaler 1/3/4/13 and 4*2^rate.
// - Arbiter has a 9-bit counter plus one overflow bit.
// - Arbiter mode: 00 idle reset, 01 measurement, 10 arbitration, 11 unused.
// - Arbitration-lost is read-only, cleared by writing zero to mode high bit.
// - Arbiter clock is half the prescaler output, or bus clock over four.
// - Measurement-done is read-only, cleared by any arbiter control write.
// - Prescaler source is bus clock or four-times clock by outside select; prescaler ticks capped at one per bus clock.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_serial_top
   import asf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        baudSourceSelect,
   output logic             txIrq,
   output logic             rxIrq,
   output logic             errIrq,
   output logic             wakeReq
);
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        txEmpty;
      logic        txComplete;
      logic        rxFull;
      logic        idle;
      logic        overrun;
      logic        noise;
      logic        framing;
      logic        parity;
      logic [7:0]  rxData;
      logic [7:0]  txBuf;
      logic [1:0]  ctl1;
      logic [7:0]  ctl2;
      logic [3:0]  ctl3;
      logic [1:0]  presc;
      logic [2:0]  rate;
      logic [1:0]  arbMode;
      logic        arbClkSel;
      asf_rx_e     rxState;
      logic [4:0]  rxRt;
      logic [3:0]  rxBits;
      logic [8:0]  rxShift;
      logic [2:0]  votes;
      logic        rxNoise;
      logic [7:0]  idleCnt;
      logic        idleArmed;
      asf_tx_e     txState;
      logic [3:0]  txRt;
      logic [3:0]  txBits;
      logic [10:0] txShift;
      logic        txd;
      logic [1:0]  arbDiv;
      logic        arbHalf;
      logic        arbTick;
      logic        txIrq;
      logic        rxIrq;
      logic        errIrq;
      logic        wakeReq;
   } asf_top_s;

   asf_top_s s_q, s_d;
   asf_baud_if bif ();

   logic [8:0] arbCount;
   logic       arbOvf;
   logic       arbLost;
   logic       arbDone;

   // ***************
   // Bus decode
   // ***************
   logic setup;
   logic access;
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic arbCtlWrite;
   logic arbLostClear;

   assign setup  = psel & ~penable;
   assign access = psel & penable & s_q.pready;
   assign wrEn   = access & pwrite;
   assign rdEn   = access & ~pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `ASF_ADDR_ARBCNT);
   assign arbCtlWrite  = wrEn && (paddr == `ASF_ADDR_ARBCTL);
   assign arbLostClear = arbCtlWrite && !pwdata[`ASF_AC_AM1];

   assign bif.prescaleSelect    = s_q.presc;
   assign bif.rateDivisorSelect = s_q.rate;
   assign bif.baudSourceSelect  = baudSourceSelect;

   asf_baud_gen u_baud (
      .core_clk (core_clk),
      .rst      (rst),
      .bif      (bif.gen)
   );

   asf_arbiter #(.CNT_W(9)) u_arb (
      .core_clk  (core_clk),
      .rst       (rst),
      .arbTick   (s_q.arbTick),
      .mode      (s_q.arbMode),
      .ctlWrite  (arbCtlWrite),
      .lostClear (arbLostClear),
      .lineLevel (rxd),
      .txLevel   (s_q.txd),
      .count     (arbCount),
      .overflow  (arbOvf),
      .lost      (arbLost),
      .done      (arbDone)
   );

   // ***************
   // Next state
   // ***************
   logic       tick;
   logic [4:0] rtNext;
   logic       rxRead;
   logic       dataWrite;
   logic       vote;
   logic [2:0] newVotes;
   logic       major;
   logic [7:0] rxByte;
   logic       rxParBit;
   logic [3:0] dataBits;
   logic       txPar;

   always_comb begin
      s_d = s_q;
      tick      = bif.oversampleTick;
      rxRead    = rdEn && (paddr == `ASF_ADDR_DATA);
      dataWrite = wrEn && (paddr == `ASF_ADDR_DATA);
      dataBits  = s_q.ctl1[`ASF_C1_PAR_EN] ? `ASF_DATA_PAR : `ASF_DATA_NOPAR;
      rtNext    = (s_q.rxRt == `ASF_RT_PER_BIT) ? 5'h01 : (s_q.rxRt + 5'h01);
      vote      = 1'b0;
      newVotes  = s_q.votes;
      major     = 1'b0;
      rxByte    = s_q.ctl1[`ASF_C1_PAR_EN] ? s_q.rxShift[7:0] : s_q.rxShift[8:1];
      rxParBit  = s_q.rxShift[8];
      txPar     = (^s_q.txBuf) ^ s_q.ctl1[`ASF_C1_PAR_ODD];

      // APB answer: registered in setup, shown in first access cycle
      s_d.pready  = setup;
      s_d.pslverr = setup & ~mapped;
      s_d.prdata  = 32'h0000_0000;
      if (setup && !pwrite) begin
         case (paddr)
            `ASF_ADDR_STATUS: s_d.prdata[7:0] = {s_q.txEmpty, s_q.txComplete, s_q.rxFull, s_q.idle,
                                                 s_q.overrun, s_q.noise, s_q.framing, s_q.parity};
            `ASF_ADDR_DATA:   s_d.prdata[7:0] = s_q.rxData;
            `ASF_ADDR_CTRL1:  s_d.prdata[1:0] = s_q.ctl1;
            `ASF_ADDR_CTRL2:  s_d.prdata[7:0] = s_q.ctl2;
            `ASF_ADDR_CTRL3:  s_d.prdata[3:0] = s_q.ctl3;
            `ASF_ADDR_BAUD:   s_d.prdata[7:0] = {2'h0, s_q.presc, 1'b0, s_q.rate};
            `ASF_ADDR_ARBCTL: s_d.prdata[7:0] = {s_q.arbMode, arbLost, s_q.arbClkSel, arbDone, 3'h0};
            `ASF_ADDR_ARBCNT: s_d.prdata[9:0] = {arbOvf, arbCount};
            default:          s_d.prdata = 32'h0000_0000;
         endcase
      end

      // Clears first, so a hardware set later in this process wins
      if (wrEn) begin
         case (paddr)
            `ASF_ADDR_STATUS: begin
               if (pwdata[`ASF_ST_IDLE]) s_d.idle = 1'b0;
               if (pwdata[`ASF_ST_OR])   s_d.overrun = 1'b0;
               if (pwdata[`ASF_ST_NF])   s_d.noise = 1'b0;
               if (pwdata[`ASF_ST_FE])   s_d.framing = 1'b0;
               if (pwdata[`ASF_ST_PE])   s_d.parity = 1'b0;
            end
            `ASF_ADDR_DATA: begin
               s_d.txBuf      = pwdata[7:0];
               s_d.txEmpty    = 1'b0;
               s_d.txComplete = 1'b0;
            end
            `ASF_ADDR_CTRL1:  s_d.ctl1 = pwdata[1:0];
            `ASF_ADDR_CTRL2:  s_d.ctl2 = {pwdata[7:2], 1'b0, pwdata[0]};
            `ASF_ADDR_CTRL3:  s_d.ctl3 = pwdata[3:0];
            `ASF_ADDR_BAUD: begin
               s_d.presc = pwdata[`ASF_BD_PRESC_LSB +: 2];
               s_d.rate  = pwdata[`ASF_BD_RATE_LSB +: 3];
            end
            `ASF_ADDR_ARBCTL: begin
               s_d.arbMode   = {pwdata[`ASF_AC_AM1], pwdata[`ASF_AC_AM0]};
               s_d.arbClkSel = pwdata[`ASF_AC_ACLK];
            end
            default: s_d.arbClkSel = s_q.arbClkSel;
         endcase
      end
      if (rxRead) s_d.rxFull = 1'b0;

      // ***************
      // Receiver
      // ***************
      if (tick && s_q.ctl2[`ASF_C2_RXEN]) begin
         case (s_q.rxState)
            ASF_RX_IDLE: begin
               if (!rxd) begin
                  s_d.rxState = ASF_RX_START;
                  s_d.rxRt    = 5'h01;
                  s_d.rxNoise = 1'b0;
                  s_d.rxBits  = 4'h0;
                  s_d.idleCnt = 8'h00;
               end else if (s_q.idleCnt == `ASF_IDLE_RT) begin
                  if (s_q.idleArmed) s_d.idle = 1'b1;
                  s_d.idleArmed = 1'b0;
               end else begin
                  s_d.idleCnt = s_q.idleCnt + 8'h01;
               end
            end
            default: begin
               s_d.rxRt = rtNext;
               if (rtNext == `ASF_RT_SAMPLE_A) newVotes[0] = rxd;
               if (rtNext == `ASF_RT_SAMPLE_B) newVotes[1] = rxd;
               if (rtNext == `ASF_RT_SAMPLE_C) newVotes[2] = rxd;
               s_d.votes = newVotes;
               major = (newVotes[0] & newVotes[1]) | (newVotes[0] & newVotes[2]) | (newVotes[1] & newVotes[2]);
               vote  = (rtNext == `ASF_RT_SAMPLE_C);
               if (vote && !(&newVotes) && (|newVotes)) s_d.rxNoise = 1'b1;
               if (vote) begin
                  case (s_q.rxState)
                     ASF_RX_START: if (major) s_d.rxState = ASF_RX_IDLE;
                     ASF_RX_DATA: begin
                        s_d.rxShift = {major, s_q.rxShift[8:1]};
                        s_d.rxBits  = s_q.rxBits + 4'h1;
                     end
                     default: begin
                        // Stop bit decided at the third sample to allow resync
                        s_d.rxState   = ASF_RX_IDLE;
                        s_d.idleCnt   = 8'h00;
                        s_d.idleArmed = 1'b1;
                        if (s_d.rxNoise) s_d.noise = 1'b1;
                        if (!major) s_d.framing = 1'b1;
                        if (s_q.ctl1[`ASF_C1_PAR_EN] &&
                            (((^rxByte) ^ rxParBit) != s_q.ctl1[`ASF_C1_PAR_ODD])) begin
                           s_d.parity = 1'b1;
                        end
                        if (s_q.rxFull && !rxRead) begin
                           s_d.overrun = 1'b1;
                        end else begin
                           s_d.rxData = rxByte;
                           s_d.rxFull = 1'b1;
                        end
                     end
                  endcase
               end
               if (rtNext == `ASF_RT_PER_BIT) begin
                  if (s_q.rxState == ASF_RX_START) s_d.rxState = ASF_RX_DATA;
                  if (s_q.rxState == ASF_RX_DATA && s_q.rxBits == dataBits) s_d.rxState = ASF_RX_STOP;
               end
            end
         endcase
      end else if (!s_q.ctl2[`ASF_C2_RXEN]) begin
         s_d.rxState = ASF_RX_IDLE;
      end

      // ***************
      // Transmitter
      // ***************
      case (s_q.txState)
         ASF_TX_IDLE: begin
            s_d.txd = ~s_q.ctl2[`ASF_C2_BRK];
            if (tick && s_q.ctl2[`ASF_C2_TXEN] && !s_q.txEmpty && !dataWrite) begin
               s_d.txShift = s_q.ctl1[`ASF_C1_PAR_EN] ? {1'b1, txPar, s_q.txBuf, 1'b0}
                                                      : {2'h3, s_q.txBuf, 1'b0};
               s_d.txBits  = s_q.ctl1[`ASF_C1_PAR_EN] ? `ASF_FRAME_PAR : `ASF_FRAME_NOPAR;
               s_d.txRt    = 4'h0;
               s_d.txd     = 1'b0;
               s_d.txState = ASF_TX_SHIFT;
               s_d.txEmpty = 1'b1;
            end else if (s_q.txEmpty && !s_q.ctl2[`ASF_C2_BRK] && !dataWrite) begin
               s_d.txComplete = 1'b1;
            end
         end
         default: begin
            if (tick) begin
               s_d.txRt = s_q.txRt + 4'h1;
               if (s_q.txRt == 4'hF) begin
                  s_d.txShift = {1'b1, s_q.txShift[10:1]};
                  s_d.txBits  = s_q.txBits - 4'h1;
                  s_d.txd     = s_q.txShift[1];
                  if (s_q.txBits == 4'h1) begin
                     s_d.txState = ASF_TX_IDLE;
                     s_d.txd     = 1'b1;
                  end
               end
            end
         end
      endcase

      // ***************
      // Arbiter clock
      // ***************
      s_d.arbTick = 1'b0;
      if (s_q.arbClkSel) begin
         if (bif.prescaleTick) begin
            s_d.arbHalf = ~s_q.arbHalf;
            s_d.arbTick = s_q.arbHalf;
         end
      end else begin
         s_d.arbDiv  = s_q.arbDiv + 2'h1;
         s_d.arbTick = (s_q.arbDiv == `ASF_ARB_BUS_DIV);
      end

      // ***************
      // Requests
      // ***************
      s_d.txIrq  = (s_q.txEmpty & s_q.ctl2[`ASF_C2_TXEIE]) |
                   (s_q.txComplete & s_q.ctl2[`ASF_C2_TX_COMPLETE_IRQ_EN]);
      s_d.rxIrq  = (s_q.rxFull & s_q.ctl2[`ASF_C2_RXFIE]) |
                   (s_q.idle & s_q.ctl2[`ASF_C2_IDLE_LINE_IRQ_EN]);
      s_d.errIrq = (s_q.overrun & s_q.ctl3[`ASF_C3_OVERRUN_IRQ_EN]) |
                   (s_q.noise & s_q.ctl3[`ASF_C3_NOISE_IRQ_EN]) |
                   (s_q.framing & s_q.ctl3[`ASF_C3_FRAMING_IRQ_EN]) |
                   (s_q.parity & s_q.ctl3[`ASF_C3_PARITY_IRQ_EN]);
      s_d.wakeReq = s_d.txIrq | s_d.rxIrq | s_d.errIrq;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q            <= '0;
         s_q.txEmpty    <= 1'b1;
         s_q.txComplete <= 1'b1;
         s_q.txd        <= 1'b1;
         s_q.rxState    <= ASF_RX_IDLE;
         s_q.txState    <= ASF_TX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign txd     = s_q.txd;
   assign txIrq   = s_q.txIrq;
   assign rxIrq   = s_q.rxIrq;
   assign errIrq  = s_q.errIrq;
   assign wakeReq = s_q.wakeReq;
endmodule

// ### tb/asf_serial_chk.sv
// Port-level assertions for the serial block
`timescale 1ns/1ps
module asf_serial_chk (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        txIrq,
   input wire logic        rxIrq,
   input wire logic        errIrq,
   input wire logic        wakeReq
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic bad = paddr > 8'h1C || paddr[1:0] != 2'h0;
   wire logic anyIrq = txIrq || rxIrq || errIrq;
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready held");
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_bad; psel && !penable && bad |=> pslverr; endproperty
   a_bad: assert property (p_bad) else $error("no error");
   property p_good; psel && !penable && !bad |=> !pslverr; endproperty
   a_good: assert property (p_good) else $error("false error");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error alone");
   property p_wide; pready |-> prdata[31:10] == 22'h0; endproperty
   a_wide: assert property (p_wide) else $error("high bits");
   property p_wake; anyIrq |-> ##[0:1] wakeReq; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_calm; !anyIrq [*2] |-> !wakeReq; endproperty
   a_calm: assert property (p_calm) else $error("stray wake");
endmodule

// ### tb/asf_remote_node.sv
// Remote serial node on the receive and transmit lines
`timescale 1ns/1ps
module asf_remote_node #(
   parameter int BIT_CYC = 64
) (
   input  wire logic core_clk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'h1;
   // Sends n bits LSB first, BIT_CYC clock cycles each; idle line rests high
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
      rxd <= 1'h1;
   endtask
   // Bounded wait for a start bit, then mid-bit samples of ten bits
   task automatic grab(output logic [9:0] f);
      for (int i = 0; i < 8000 && txd !== 1'h0; i++) @(posedge core_clk);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txd;
         repeat (BIT_CYC) @(posedge core_clk);
      end
   endtask
endmodule

// ### tb/asf_serial_top_tb_top.sv
// Self-checking bench for the serial block
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_serial_top_tb_top;
   localparam int BC = 384; // Bit time with BAUD 0x11: 16 ticks of 3*4*2 cycles
   logic        core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        rxd, txd, pready, pslverr, txIrq, rxIrq, errIrq, wakeReq;
   logic        bsrc = 1'h0;
   logic [9:0]  tf;
   int          num_errors = 0, tests_run = 0;
   always #4 core_clk = ~core_clk;
   asf_serial_top DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rxd, .txd, .baudSourceSelect(bsrc), .txIrq, .rxIrq, .errIrq, .wakeReq);
   asf_remote_node #(.BIT_CYC(BC)) peer (.core_clk, .txd, .rxd);
   task automatic give_verdict;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // One edge gap before setup so psel is never assigned twice in a step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) chk(32'h0, 32'h1);
      if (pready !== 1'h1) give_verdict();
      rv = prdata;
      {psel, penable} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk(rv & m, e);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'h0;
      rd(`ASF_ADDR_STATUS, 32'hFF, 32'hC0);
      rd(8'h22, 32'hFFFFFFFF, 32'h0);
      wr(`ASF_ADDR_BAUD, 32'h11);
      wr(`ASF_ADDR_CTRL3, 32'h0F);
      wr(`ASF_ADDR_CTRL2, 32'hFC);
      wr(`ASF_ADDR_DATA, 32'h3C);
      peer.grab(tf);
      chk(tf, 10'h278);
      repeat (BC) @(posedge core_clk);
      rd(`ASF_ADDR_STATUS, 32'hC0, 32'hC0);
      chk(txIrq, 1'h1);
      $display("test transmit ended");
      peer.send({1'h1, 8'hA5, 1'h0}, 10);
      rd(`ASF_ADDR_STATUS, 32'h2F, 32'h20);
      chk(rxIrq, 1'h1);
      rd(`ASF_ADDR_DATA, 32'hFF, 32'hA5);
      repeat (4000) @(posedge core_clk);
      rd(`ASF_ADDR_STATUS, 32'h30, 32'h10);
      wr(`ASF_ADDR_STATUS, 32'h1F);
      $display("test receive ended");
      peer.send({1'h1, 8'h11, 1'h0}, 10);
      peer.send({1'h1, 8'h22, 1'h0}, 10);
      rd(`ASF_ADDR_STATUS, 32'h08, 32'h08);
      chk(errIrq, 1'h1);
      rd(`ASF_ADDR_DATA, 32'hFF, 32'h11);
      wr(`ASF_ADDR_STATUS, 32'h1F);
      peer.send({1'h0, 8'h55, 1'h0}, 10);
      rd(`ASF_ADDR_STATUS, 32'h02, 32'h02);
      // Low stop bit leaves a false start behind; let the line idle first
      repeat (BC) @(posedge core_clk);
      wr(`ASF_ADDR_CTRL1, 32'h02);
      peer.send({1'h1, 1'h0, 8'h01, 1'h0}, 11);
      rd(`ASF_ADDR_STATUS, 32'h01, 32'h01);
      $display("test errors ended");
      wr(`ASF_ADDR_ARBCTL, 32'h40);
      peer.send(12'h0, 1);
      repeat (BC) @(posedge core_clk);
      rd(`ASF_ADDR_ARBCTL, 32'hC8, 32'h48);
      rd(`ASF_ADDR_ARBCNT, 32'h3FF, 32'h060);
      wr(`ASF_ADDR_ARBCTL, 32'h00);
      rd(`ASF_ADDR_ARBCTL, 32'h08, 32'h00);
      rd(`ASF_ADDR_ARBCNT, 32'h3FF, 32'h0);
      // Four-times source over prescaler 4 gives one tick per clock, halved
      bsrc <= 1'h1;
      wr(`ASF_ADDR_BAUD, 32'h20);
      wr(`ASF_ADDR_ARBCTL, 32'h50);
      peer.send(12'h0, 1);
      repeat (BC) @(posedge core_clk);
      rd(`ASF_ADDR_ARBCNT, 32'h3FF, 32'h0C0);
      wr(`ASF_ADDR_ARBCTL, 32'h80);
      peer.send(12'h0, 1);
      rd(`ASF_ADDR_ARBCTL, 32'h20, 32'h20);
      wr(`ASF_ADDR_ARBCTL, 32'h00);
      rd(`ASF_ADDR_ARBCTL, 32'h20, 32'h00);
      $display("test arbiter ended");
      give_verdict();
   end
endmodule
bind asf_serial_top asf_serial_chk u_chk (.core_clk, .rst, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .txIrq, .rxIrq, .errIrq, .wakeReq);
